// ---- rtl/gtpf_consts.vh ----
// Purpose: constants of the time-information packet framer
// Assumes: included by gtpf_framer.v and by the testbench
// Notes:   byte offsets inside the payload count from its first byte
`ifndef GTPF_CONSTS_VH
`define GTPF_CONSTS_VH
// ****************************************
// timing
// ****************************************
`define GTPF_CLK_HZ     40000000
`define GTPF_NS_PER_S   1000000000
`define GTPF_TICK_S     1
`define GTPF_NMEA_TO_S  2
`define GTPF_US_NS      1000
// ****************************************
// register map and reset values
// ****************************************
`define GTPF_REG_CTRL   8'h00
`define GTPF_REG_IP     8'h04
`define GTPF_REG_MACL   8'h08
`define GTPF_REG_MACH   8'h0C
`define GTPF_REG_STAT   8'h10
`define GTPF_REG_USEC   8'h14
`define GTPF_CTRL_GGA   0
`define GTPF_CTRL_EN    1
`define GTPF_CTRL_RST   2'h2
`define GTPF_IP_RST     32'hC0A801C9
`define GTPF_MAC_RST    48'h020000000001
`define GTPF_RESP_OK    2'h0
`define GTPF_RESP_ERR   2'h2
// ****************************************
// frame layout
// ****************************************
`define GTPF_INIT_TOD   48'h200520000000
`define GTPF_HDR_LEN    10'h02A
`define GTPF_LAST_IDX   10'h229
`define GTPF_SENT_LEN   7'h64
`define GTPF_P_DATE     10'h002
`define GTPF_P_USEC     10'h00E
`define GTPF_P_SENT     10'h012
`define GTPF_P_RSV      10'h076
`define GTPF_P_STAT     10'h1FA
`define GTPF_P_LOCK     10'h1FB
`define GTPF_ETYPE      16'h0800
`define GTPF_IPW_VER    16'h4500
`define GTPF_IPW_LEN    16'h021C
`define GTPF_IPW_ID     16'h0000
`define GTPF_IPW_FRAG   16'h4000
`define GTPF_IPW_TTLP   16'h8011
`define GTPF_UDP_SRC    16'h2710
`define GTPF_UDP_DST    16'h277E
`define GTPF_UDP_LEN    16'h0208
`define GTPF_MARK       16'hFFEE
`define GTPF_FILL       8'hDF
`endif

// ---- rtl/gtpf_framer.v ----
// Purpose: once-per-second time-information UDP frame generator
// Assumes: nmea bytes come from a UART on clk; pps_in is asynchronous
// Notes:   time of day is held as BCD, microseconds in binary; register bus is AXI4-Lite
`timescale 1ns/1ps
`include "gtpf_consts.vh"
module gtpf_framer #(
  parameter CLK_HZ  = `GTPF_CLK_HZ,
  parameter NMEA_TO = `GTPF_NMEA_TO_S * `GTPF_CLK_HZ
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pps_in,
  input  wire [7:0]  nmea_data,
  input  wire        nmea_valid,
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  output reg         tx_last,
  input  wire        tx_ready,
  output reg  [47:0] tod_bcd,
  output reg  [31:0] tod_usec,
  output reg         pps_locked,
  output reg         nmea_locked
);
  localparam [31:0] PERIOD = CLK_HZ * `GTPF_TICK_S;
  localparam [31:0] LOCK_WIN = PERIOD + PERIOD / 8;
  localparam [31:0] TO_CYC = NMEA_TO;
  localparam [31:0] US_CYC = CLK_HZ / (`GTPF_NS_PER_S / `GTPF_US_NS);

  // ****************************************
  // functions
  // ****************************************
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [7:0] days_in;
    input [7:0] m;
    input [7:0] y;
    reg   [4:0] s;
    begin
      s = {y[7:4], 1'b0} + {1'b0, y[3:0]};
      case (m)
        8'h02:   days_in = (s[1:0] == 2'h0) ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
        default: days_in = 8'h31;
      endcase
    end
  endfunction

  function [7:0] hdr_char;
    input       gga;
    input [3:0] pos;
    begin
      case (pos)
        4'h0:    hdr_char = 8'h47;
        4'h1:    hdr_char = 8'h50;
        4'h2:    hdr_char = gga ? 8'h47 : 8'h52;
        4'h3:    hdr_char = gga ? 8'h47 : 8'h4D;
        default: hdr_char = gga ? 8'h41 : 8'h43;
      endcase
    end
  endfunction

  function [7:0] half;
    input [15:0] w;
    input        hi;
    begin
      half = hi ? w[15:8] : w[7:0];
    end
  endfunction

  function [31:0] wmask;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  st;
    integer      i;
    begin
      wmask = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i]) wmask[8*i +: 8] = d[8*i +: 8];
    end
  endfunction

  // ****************************************
  // registers and bus slave
  // ****************************************
  reg  [1:0]  ctrl;
  reg  [31:0] src_ip;
  reg  [47:0] src_mac;
  reg         busy;
  wire        gga = ctrl[`GTPF_CTRL_GGA];
  wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                      & ~s_axi_bvalid;
  wire        rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire [31:0] mach_w = wmask({16'h0000, src_mac[47:32]}, s_axi_wdata,
                             s_axi_wstrb);

  always @(posedge clk) begin
    s_axi_awready <= wr_go;
    s_axi_wready  <= wr_go;
    s_axi_arready <= rd_go;
    if (rst) begin
      ctrl         <= `GTPF_CTRL_RST;
      src_ip       <= `GTPF_IP_RST;
      src_mac      <= `GTPF_MAC_RST; // arbitrary local default
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GTPF_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `GTPF_RESP_OK;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `GTPF_RESP_OK;
        case (s_axi_awaddr)
          `GTPF_REG_CTRL: if (s_axi_wstrb[0]) ctrl <= s_axi_wdata[1:0];
          `GTPF_REG_IP:   src_ip <= wmask(src_ip, s_axi_wdata, s_axi_wstrb);
          `GTPF_REG_MACL: src_mac[31:0] <= wmask(src_mac[31:0],
                                                 s_axi_wdata, s_axi_wstrb);
          `GTPF_REG_MACH: src_mac[47:32] <= mach_w[15:0];
          `GTPF_REG_STAT, `GTPF_REG_USEC: s_axi_bresp <= `GTPF_RESP_OK;
          default:        s_axi_bresp <= `GTPF_RESP_ERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `GTPF_RESP_OK;
        case (s_axi_araddr)
          `GTPF_REG_CTRL: s_axi_rdata <= {30'h0, ctrl};
          `GTPF_REG_IP:   s_axi_rdata <= src_ip;
          `GTPF_REG_MACL: s_axi_rdata <= src_mac[31:0];
          `GTPF_REG_MACH: s_axi_rdata <= {16'h0000, src_mac[47:32]};
          `GTPF_REG_STAT: s_axi_rdata <= {29'h0, busy, nmea_locked,
                                          pps_locked};
          `GTPF_REG_USEC: s_axi_rdata <= tod_usec;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GTPF_RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // one-second tick and microseconds
  // ****************************************
  reg  [1:0]  pps_sync;
  reg         pps_d;
  reg  [31:0] tcnt;
  reg         tick;
  reg  [7:0]  uscnt;
  wire        pps_rise = pps_sync[1] & ~pps_d;

  always @(posedge clk) begin
    pps_sync <= {pps_sync[0], pps_in};
    tick     <= 1'b0;
    if (rst) begin
      pps_d      <= 1'b0;
      tcnt       <= 32'h00000000;
      pps_locked <= 1'b0;
      uscnt      <= 8'h00;
      tod_usec   <= 32'h00000000;
    end else begin
      pps_d <= pps_sync[1];
      if (pps_rise) begin
        tcnt       <= 32'h00000000;
        tick       <= 1'b1;
        pps_locked <= 1'b1;
      end else if ((!pps_locked && tcnt == PERIOD - 32'h1) ||
                   (pps_locked && tcnt == LOCK_WIN - 32'h1)) begin
        tcnt       <= 32'h00000000;
        tick       <= 1'b1;
        pps_locked <= 1'b0;
      end else begin
        tcnt <= tcnt + 32'h1;
      end
      if (pps_rise || tick) begin
        uscnt    <= 8'h00;
        tod_usec <= 32'h00000000;
      end else if (uscnt == US_CYC[7:0] - 8'h1) begin
        uscnt    <= 8'h00;
        tod_usec <= tod_usec + 32'h1;
      end else begin
        uscnt <= uscnt + 8'h1;
      end
    end
  end

  // ****************************************
  // sentence parser
  // ****************************************
  reg  [7:0]  sbuf [0:255];
  reg         in_sent, hdr_ok, star, got_t, got_d, bank, fresh, c_hasd;
  reg  [4:0]  field;
  reg  [3:0]  cpos;
  reg  [6:0]  wpos, c_len;
  reg  [23:0] sh, p_time, p_date, c_time, c_date;
  reg  [7:0]  p_stat, c_stat;
  reg  [31:0] to_cnt;
  wire [7:0]  b = nmea_data;
  wire        sep = (b == 8'h2C) || (b == 8'h2A);
  wire        done = nmea_valid & in_sent & star & (cpos == 4'h1);
  wire        commit = done & hdr_ok & got_t & (gga | got_d);

  always @(posedge clk) begin
    if (nmea_valid && (b == 8'h24 || (in_sent && wpos < `GTPF_SENT_LEN)))
      sbuf[{~bank, (b == 8'h24) ? 7'h00 : wpos}] <= b;
    if (rst) begin
      in_sent <= 1'b0; hdr_ok <= 1'b0; star <= 1'b0;
      got_t   <= 1'b0; got_d  <= 1'b0; bank <= 1'b0;
      fresh   <= 1'b0; c_hasd <= 1'b0; field <= 5'h00;
      cpos    <= 4'h0; wpos   <= 7'h00; c_len <= 7'h00;
      sh      <= 24'h0; p_time <= 24'h0; p_date <= 24'h0;
      c_time  <= 24'h0; c_date <= 24'h0; p_stat <= 8'h00;
      c_stat  <= 8'h00; to_cnt <= 32'h0; nmea_locked <= 1'b0;
    end else begin
      if (nmea_valid && b == 8'h24) begin
        in_sent <= 1'b1; hdr_ok <= 1'b1; star <= 1'b0;
        got_t   <= 1'b0; got_d  <= 1'b0; field <= 5'h00;
        cpos    <= 4'h0; wpos   <= 7'h01; p_stat <= 8'h00;
      end else if (nmea_valid && in_sent) begin
        if (wpos < `GTPF_SENT_LEN) wpos <= wpos + 7'h1;
        if (star) begin
          cpos <= cpos + 4'h1;
          if (done) in_sent <= 1'b0;
        end else if (sep) begin
          if (field == 5'h01 && cpos >= 4'h6) begin
            p_time <= sh;
            got_t  <= 1'b1;
          end
          if (!gga && field == 5'h09 && cpos >= 4'h6) begin
            p_date <= sh;
            got_d  <= 1'b1;
          end
          if (field != 5'h1F) field <= field + 5'h01;
          cpos <= 4'h0;
          star <= (b == 8'h2A);
        end else begin
          if (field == 5'h00 && (cpos > 4'h4 || b != hdr_char(gga, cpos)))
            hdr_ok <= 1'b0;
          if (cpos < 4'h6) sh <= {sh[19:0], b[3:0]};
          if (cpos == 4'h0 && ((!gga && field == 5'h02) ||
                               (gga && field == 5'h06)))
            p_stat <= b;
          if (cpos != 4'hF) cpos <= cpos + 4'h1;
        end
      end
      if (commit) begin
        c_time <= p_time;
        c_date <= p_date;
        c_hasd <= ~gga;
        c_stat <= p_stat;
        c_len  <= (wpos < `GTPF_SENT_LEN) ? wpos + 7'h1 : `GTPF_SENT_LEN;
        bank   <= ~bank;
      end
      // a new sentence outranks the tick that consumes the old one
      fresh <= commit | (fresh & ~tick);
      if (commit) begin
        nmea_locked <= 1'b1;
        to_cnt      <= 32'h0;
      end else if (nmea_locked) begin
        if (to_cnt == TO_CYC - 32'h1) nmea_locked <= 1'b0;
        to_cnt <= to_cnt + 32'h1;
      end
    end
  end

  // ****************************************
  // time of day
  // ****************************************
  reg  [7:0] yr, mo, dy, hr, mi, se;
  reg  [7:0] next_yr, next_mo, next_dy, next_hr, next_mi, next_se;

  always @* begin
    {yr, mo, dy} = (fresh && c_hasd) ? {c_date[7:0], c_date[15:8],
                                        c_date[23:16]} : tod_bcd[47:24];
    {hr, mi, se} = fresh ? c_time : tod_bcd[23:0];
    {next_yr, next_mo, next_dy, next_hr, next_mi, next_se} =
      {yr, mo, dy, hr, mi, bcd_inc(se)};
    if (se == 8'h59) begin
      next_se = 8'h00;
      next_mi = bcd_inc(mi);
      if (mi == 8'h59) begin
        next_mi = 8'h00;
        next_hr = bcd_inc(hr);
        if (hr == 8'h23) begin
          next_hr = 8'h00;
          next_dy = bcd_inc(dy);
          if (dy == days_in(mo, yr)) begin
            next_dy = 8'h01;
            next_mo = bcd_inc(mo);
            if (mo == 8'h12) begin
              next_mo = 8'h01;
              next_yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
            end
          end
        end
      end
    end
  end

  always @(posedge clk) begin
    if (rst)
      tod_bcd <= `GTPF_INIT_TOD;
    else if (tick)
      tod_bcd <= {next_yr, next_mo, next_dy, next_hr, next_mi, next_se};
  end

  // ****************************************
  // frame byte generator
  // ****************************************
  reg  [9:0]  idx, p;
  reg  [7:0]  fbyte;
  reg         fbank;
  reg  [6:0]  flen;
  reg  [3:0]  k;
  reg  [2:0]  j;
  reg  [47:0] tb;
  wire [19:0] s1 = `GTPF_IPW_VER + `GTPF_IPW_LEN + `GTPF_IPW_ID
                 + `GTPF_IPW_FRAG + `GTPF_IPW_TTLP + 20'h1FFFE
                 + src_ip[31:16] + src_ip[15:0];
  wire [16:0] s2 = s1[15:0] + s1[19:16];
  wire [15:0] csum = ~(s2[15:0] + {15'h0, s2[16]});

  always @* begin
    p  = idx - `GTPF_HDR_LEN;
    k  = 4'hB - idx[3:0];
    j  = 3'h6 - p[3:1];
    tb = {tod_bcd[47:24], tod_bcd[7:0], tod_bcd[15:8], tod_bcd[23:16]};
    fbyte = 8'h00;
    if (idx < 10'h006) fbyte = 8'hFF;
    else if (idx < 10'h00C) fbyte = src_mac[{k[2:0], 3'h0} +: 8];
    else if (idx < 10'h01A) begin
      case (idx[4:0])
        5'h0C: fbyte = half(`GTPF_ETYPE, 1'b1);
        5'h0D: fbyte = half(`GTPF_ETYPE, 1'b0);
        5'h0E: fbyte = half(`GTPF_IPW_VER, 1'b1);
        5'h10: fbyte = half(`GTPF_IPW_LEN, 1'b1);
        5'h11: fbyte = half(`GTPF_IPW_LEN, 1'b0);
        5'h14: fbyte = half(`GTPF_IPW_FRAG, 1'b1);
        5'h16: fbyte = half(`GTPF_IPW_TTLP, 1'b1);
        5'h17: fbyte = half(`GTPF_IPW_TTLP, 1'b0);
        5'h18: fbyte = csum[15:8];
        5'h19: fbyte = csum[7:0];
        default: fbyte = 8'h00;
      endcase
    end else if (idx < 10'h01E) fbyte = src_ip[{k[1:0] + 2'h2, 3'h0} +: 8];
    else if (idx < 10'h022) fbyte = 8'hFF;
    else if (idx < `GTPF_HDR_LEN) begin
      case (idx[2:0])
        3'h2: fbyte = half(`GTPF_UDP_SRC, 1'b1);
        3'h3: fbyte = half(`GTPF_UDP_SRC, 1'b0);
        3'h4: fbyte = half(`GTPF_UDP_DST, 1'b1);
        3'h5: fbyte = half(`GTPF_UDP_DST, 1'b0);
        3'h6: fbyte = half(`GTPF_UDP_LEN, 1'b1);
        3'h7: fbyte = half(`GTPF_UDP_LEN, 1'b0);
        default: fbyte = 8'h00;
      endcase
    end else if (p < `GTPF_P_DATE)
      fbyte = half(`GTPF_MARK, ~p[0]);
    else if (p < `GTPF_P_USEC)
      fbyte = {4'h3, p[0] ? tb[{j, 3'h4} +: 4] : tb[{j, 3'h0} +: 4]};
    else if (p < `GTPF_P_SENT)
      fbyte = tod_usec[{p[1:0] - 2'h2, 3'h0} +: 8];
    else if (p < `GTPF_P_RSV) begin
      if (p[6:0] - 7'h12 < flen)
        fbyte = sbuf[{fbank, p[6:0] - 7'h12}];
    end else if (p < `GTPF_P_STAT) fbyte = `GTPF_FILL;
    else if (p == `GTPF_P_STAT) fbyte = nmea_locked ? c_stat : 8'h00;
    else if (p == `GTPF_P_LOCK) fbyte = {7'h00, pps_locked};
    else fbyte = 8'h00;
  end

  always @(posedge clk) begin
    if (rst) begin
      busy     <= 1'b0;
      idx      <= 10'h000;
      fbank    <= 1'b0;
      flen     <= 7'h00;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end else begin
      if (tick && !busy && ctrl[`GTPF_CTRL_EN]) begin
        busy  <= 1'b1;
        idx   <= 10'h000;
        fbank <= bank;
        flen  <= c_len;
      end else if (busy && (!tx_valid || tx_ready)) begin
        tx_data  <= fbyte;
        tx_valid <= 1'b1;
        tx_last  <= (idx == `GTPF_LAST_IDX);
        idx      <= idx + 10'h001;
        if (idx == `GTPF_LAST_IDX) busy <= 1'b0;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
    end
  end
endmodule // gtpf_framer

// ---- sim/gtpf_monitor.sv ----
// Purpose: port checks of the time frame generator
// Assumes: bound to every gtpf_framer
// Notes:   idx counts accepted bytes of the frame under way
`timescale 1ns/1ps
module gtpf_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        pps_locked
);
  logic [9:0] idx;
  always_ff @(posedge clk) begin
    if (rst)
      idx <= 10'h000;
    else if (tx_valid && tx_ready)
      idx <= tx_last ? 10'h000 : idx + 10'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence s_wr_ack;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
  endsequence
  sequence s_byte(int n);
    tx_valid && idx == n;
  endsequence
  AST_WR_ACK: assert property (s_wr_req |=> s_wr_ack)
    else $error("write not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_RD_ACK: assert property (s_axi_arvalid && !s_axi_arready
    && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("frame byte changed while stalled");
  AST_LAST_POS: assert property (tx_valid && tx_last |-> idx == 553)
    else $error("frame end misplaced");
  AST_DEST_MAC: assert property (tx_valid && idx < 6 |-> tx_data == 8'hFF)
    else $error("destination not broadcast");
  AST_ETYPE: assert property (s_byte(12) |-> tx_data == 8'h08)
    else $error("ethertype high byte wrong");
  AST_ETYPE_LO: assert property (s_byte(13) |-> tx_data == 8'h00)
    else $error("ethertype low byte wrong");
  AST_UDP_LEN: assert property (s_byte(39) |-> tx_data == 8'h08)
    else $error("udp length wrong");
  AST_MARKER: assert property (s_byte(42) |-> tx_data == 8'hFF)
    else $error("marker wrong");
  AST_FILL: assert property (tx_valid && idx >= 160 && idx <= 547
    |-> tx_data == 8'hDF) else $error("reserved fill wrong");
  AST_LOCK: assert property (s_byte(549)
    |-> tx_data == {7'h00, pps_locked}) else $error("lock byte wrong");
  AST_TAIL: assert property (tx_valid && idx >= 550 |-> tx_data == 8'h00)
    else $error("trailing bytes not zero");
endmodule // gtpf_monitor
bind gtpf_framer gtpf_monitor u_mon (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready), .pps_locked(pps_locked));

// ---- sim/gtpf_host_model.sv ----
// Purpose: receiver and network host beside the frame generator
// Assumes: sentences and pulses are started by the bench
// Notes:   host stalls one cycle in four
`timescale 1ns/1ps
module gtpf_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic [7:0]      nmea_data,
  output logic            nmea_valid,
  output logic            pps_in
);
  logic [7:0] frm [0:553];
  logic [9:0] nb = 10'h000;
  logic [1:0] cyc = 2'h0;
  int         nfrm = 0;
  int         flen = 0;
  initial begin
    tx_ready = 1'b0;
    nmea_data = 8'h00;
    nmea_valid = 1'b0;
    pps_in = 1'b0;
  end
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    tx_ready <= (cyc != 2'h3);
    if (tx_valid && tx_ready) begin
      if (nb <= 10'h229)
        frm[nb] <= tx_data;
      nb <= tx_last ? 10'h000 : nb + 10'h001;
      if (tx_last) begin
        flen <= nb + 1;
        nfrm <= nfrm + 1;
      end
    end
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      nmea_data <= s[i];
      nmea_valid <= 1'b1;
    end
    @(posedge clk);
    nmea_valid <= 1'b0;
    nmea_data <= ~nmea_data;
  endtask
  task automatic pulse();
    @(posedge clk);
    pps_in <= 1'b1;
    repeat (4) @(posedge clk);
    pps_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // gtpf_host_model

// ---- sim/testbench.sv ----
// Purpose: self-checking bench of the time frame generator
// Assumes: host model answers the frame stream
// Notes:   one free-run second shrunk to 2000 cycles
`timescale 1ns/1ps
`include "gtpf_consts.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  tx_data, nmea_data;
  wire         tx_valid, tx_last, tx_ready, nmea_valid, pps_in;
  wire         pps_locked, nmea_locked;
  wire  [47:0] tod_bcd;
  int          err_count = 0;
  int          checks = 0;
  gtpf_framer #(.CLK_HZ(2000), .NMEA_TO(4000)) dut (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pps_in(pps_in),
    .nmea_data(nmea_data), .nmea_valid(nmea_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .tod_bcd(tod_bcd), .tod_usec(), .pps_locked(pps_locked),
    .nmea_locked(nmea_locked));
  gtpf_host_model m (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .nmea_data(nmea_data),
    .nmea_valid(nmea_valid), .pps_in(pps_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk_b(input string n, input logic [7:0] e,
                       input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_v(input string n, input logic [47:0] e,
                       input logic [47:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic [1:0] got;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    got = bresp;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    chk_v("bresp", r, got);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic [31:0] got;
    logic [1:0]  rr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    got = rdata;
    rr = rresp;
    arvalid <= 1'b0;
    rready <= 1'b0;
    chk_v("rdata", d, got);
    chk_v("rresp", r, rr);
  endtask
  task automatic wait_frame();
    int n0;
    n0 = m.nfrm;
    for (int i = 0; i < 4000 && m.nfrm == n0; i++) @(posedge clk);
    #1;
    chk_v("frame seen", 48'h1, {47'h0, m.nfrm != n0});
    chk_v("frame length", 48'h22A, 48'(m.flen));
  endtask
  task automatic chk_time(input logic [47:0] t);
    logic [7:0] f;
    int         p;
    for (int k = 0; k < 6; k++) begin
      f = t[40-8*k +: 8];
      p = (k < 3) ? 44 + 2*k : 60 - 2*k;
      chk_b("digit low", {4'h3, f[3:0]}, m.frm[p]);
      chk_b("digit high", {4'h3, f[7:4]}, m.frm[p+1]);
    end
  endtask
  task automatic chk_tail(input logic [7:0] st, input logic [7:0] lk);
    chk_b("marker", 8'hEE, m.frm[43]);
    for (int i = 160; i < 548; i++) chk_b("fill", 8'hDF, m.frm[i]);
    chk_b("status", st, m.frm[548]);
    chk_b("lock flag", lk, m.frm[549]);
    for (int i = 550; i < 554; i++) chk_b("tail", 8'h00, m.frm[i]);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    chk_v("tod at reset", 48'h200520000000, tod_bcd);
    axi_rd(`GTPF_REG_IP, 32'hC0A801C9, `GTPF_RESP_OK);
    axi_rd(`GTPF_REG_CTRL, 32'h2, `GTPF_RESP_OK);
    axi_rd(`GTPF_REG_MACH, 32'h200, `GTPF_RESP_OK);
    axi_rd(8'h20, 32'h0, `GTPF_RESP_ERR);
    axi_wr(8'h20, 32'hFFFFFFFF, `GTPF_RESP_ERR);
    axi_wr(`GTPF_REG_IP, 32'hC0A80105, `GTPF_RESP_OK);
  endtask
  task automatic t_free();
    logic [7:0]  h [0:41];
    logic [31:0] s;
    h = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h01, 8'h08, 8'h00, 8'h45, 8'h00, 8'h02, 8'h1C,
          8'h00, 8'h00, 8'h40, 8'h00, 8'h80, 8'h11, 8'h00, 8'h00, 8'hC0,
          8'hA8, 8'h01, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h27, 8'h10,
          8'h27, 8'h7E, 8'h02, 8'h08, 8'h00, 8'h00};
    s = 32'h0;
    wait_frame();
    for (int i = 0; i < 42; i++)
      if (i < 24 || i > 25)
        chk_b("header", h[i], m.frm[i]);
    for (int i = 14; i < 34; i += 2) s += {m.frm[i], m.frm[i+1]};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    chk_v("ip checksum", 48'hFFFF, {32'h0, s[15:0]});
    chk_v("tod tick", 48'h200520000001, tod_bcd);
    chk_time(48'h200520000001);
    chk_tail(8'h00, 8'h00);
  endtask
  task automatic t_rmc();
    string s;
    s = "$GPRMC,235959.00,A,0000.0,N,00000.0,E,0.0,,311299,,,A*4F";
    m.send(s);
    m.pulse();
    chk_v("tod rollover", 48'h000101000000, tod_bcd);
    chk_v("pps lock", 48'h1, pps_locked);
    chk_v("nmea lock", 48'h1, nmea_locked);
    wait_frame();
    chk_time(48'h000101000000);
    for (int i = 0; i < s.len(); i++)
      chk_b("sentence", s[i], m.frm[60+i]);
    chk_tail(8'h41, 8'h01);
  endtask
  task automatic t_gga();
    axi_wr(`GTPF_REG_CTRL, 32'h3, `GTPF_RESP_OK);
    m.send("$GPGGA,120000.50,0.0,N,0.0,E,2,08,0.9,1.0,M,1.0,M,,*5A");
    m.pulse();
    chk_v("tod gga", 48'h000101120001, tod_bcd);
    wait_frame();
    chk_time(48'h000101120001);
    chk_tail(8'h32, 8'h01);
  endtask
  task automatic t_lost();
    int n0;
    n0 = m.nfrm;
    repeat (6000) @(posedge clk);
    chk_v("free frames", 48'h1, {47'h0, m.nfrm - n0 >= 2});
    chk_v("pps unlock", 48'h0, pps_locked);
    chk_v("nmea unlock", 48'h0, nmea_locked);
    wait_frame();
    chk_v("tod free run", 48'h000101120004, tod_bcd);
    chk_tail(8'h00, 8'h00);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #750000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_regs();
    t_free();
    t_rmc();
    t_gga();
    t_lost();
    end_sim();
  end
endmodule // testbench
